/* logic/tcc_chan.sv */
/*
 * One 16-bit timer channel: live count, three compare/capture values, sticky status,
 * and the waveform actions on the two channel lines.
 * Assumes clock selection lives upstream and supplies a count tick pulse and a clock-active
 * level; capture edge detection supplies load pulses; inputs are synchronous to clk_sys_i.
 */
// Added by the designer: the plain strobed port.
// Overview of operation
// (RL1) Period match in waveform mode applies line A period action code.
// (RL2) External event applies line A external action: none, set, clear, toggle.
// (RL3) Software trigger applies line A software action with the same codes.
// (RL4) Second compare match applies its line B action.
// (RL5) Period match applies line B period action.
// (RL6) External event applies line B external action.
// (RL7) Software trigger applies line B software action.
// (RL8) Live count readable at 0x10, bits 15..0, upper bits zero.
// (RL9) First value at 0x14 writable only in waveform mode, always readable.
// (RL10) Second value at 0x18 follows the same access rule.
// (RL11) Period value at 0x1c read/write in both modes.
// (RL12) Count and the three value registers reset to zero.
// (RL13) Wrap flag, status bit 0, set on overflow, cleared by status read.
// (RL14) Capture mode: overrun flag when a value reloads unread; zero otherwise.
// (RL15) Waveform mode: first match flag on count equal first value.
// (RL16) Waveform mode: second match flag on count equal second value.
// (RL17) Period match flag in both modes, cleared by status read.
// (RL18) Capture mode: first capture flag when first value loads.
// (RL19) Capture mode: second capture flag when second value loads.
// (RL20) External trigger flag, cleared by status read.
// (RL21) Status bit 16 shows counter clock enabled; not cleared by read.
// (RL22) Status bit 17 shows line A: pin in capture, driven level in waveform.
// (RL23) Status bit 18 shows line B the same way.
// (RL24) Mode bit high selects waveform mode, low selects capture mode.
// (RL25) An event in the clearing read cycle keeps its flag set.
// (RL26) Line actions resolve: software, then external event, then compare matches.
`timescale 1ns/1ps
`include "tcc_chan_regs.svh"
module tcc_chan #(
	parameter int CNT_W = 16
) (
	// clock and reset
	input  wire logic              clk_sys_i,
	input  wire logic              rst_i,
	// register port
	input  wire tcc_pkg::tcc_addr_t addr_i,
	input  wire tcc_pkg::tcc_data_t wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output tcc_pkg::tcc_data_t     rdata_o,
	// counter clock from the clock selector
	input  wire logic              count_tick_i,
	input  wire logic              count_clk_en_i,
	// events from trigger and capture logic
	input  wire logic              ext_event_i,
	input  wire logic              ext_trigger_i,
	input  wire logic              load_first_i,
	input  wire logic              load_second_i,
	// channel line a
	input  wire logic              line_a_i,
	output logic                   line_a_o,
	output logic                   line_a_oe_o,
	// channel line b
	input  wire logic              line_b_i,
	output logic                   line_b_o,
	output logic                   line_b_oe_o
);
	import tcc_pkg::*;

	logic [CNT_W-1:0]  live_count_reg;
	logic [CNT_W-1:0]  first_value_reg;
	logic [CNT_W-1:0]  second_value_reg;
	logic [CNT_W-1:0]  period_value_reg;
	tcc_data_t         mode_reg;
	tcc_data_t         rdata_next;
	logic              first_pend_reg;
	logic              second_pend_reg;
	logic              wave;
	logic              step;
	logic [CNT_W-1:0]  count_next;
	logic              wrap_hit;
	logic              first_hit;
	logic              second_hit;
	logic              period_hit;
	logic              sw_trig;
	logic              load_first;
	logic              load_second;
	logic              overrun_hit;
	logic              status_rd;
	logic [`TCC_FLAG_COUNT-1:0] flag_set;
	logic [`TCC_FLAG_COUNT-1:0] flag_en;
	logic [`TCC_FLAG_COUNT-1:0] flags;
	logic              view_a;
	logic              view_b;

	tcc_line_if        lna ();
	tcc_line_if        lnb ();

	// decoded bus strobes and mode
	assign wave      = mode_reg[`TCC_MODE_WAVE]; // [RL24]
	assign status_rd = rd_i && addr_i == `TCC_OFF_STATUS;
	assign sw_trig   = wr_i && addr_i == `TCC_OFF_CTRL && wdata_i[`TCC_CTRL_SWTRIG];

	// counter advance and match detection on arrival at a value
	assign step        = count_tick_i && count_clk_en_i;
	assign count_next  = live_count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
	assign wrap_hit    = step && live_count_reg == `TCC_CNT_MAX; // [RL13]
	assign first_hit   = step && count_next == first_value_reg;
	assign second_hit  = step && count_next == second_value_reg;
	assign period_hit  = step && count_next == period_value_reg;

	// capture loads count only in capture mode
	assign load_first  = load_first_i && !wave;
	assign load_second = load_second_i && !wave;
	assign overrun_hit = (load_first && first_pend_reg) || (load_second && second_pend_reg); // [RL14]

	// live count, free running on the selected clock
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			live_count_reg <= `TCC_CNT_RESET; // [RL12]
		end else if (step) begin
			live_count_reg <= count_next; // [RL8]
		end
	end

	// mode register: waveform select and line action fields
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			mode_reg <= `TCC_MODE_RESET;
		end else if (wr_i && addr_i == `TCC_OFF_MODE) begin
			mode_reg <= wdata_i;
		end
	end

	// first value: software writes in waveform mode, captures in capture mode
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			first_value_reg <= `TCC_CNT_RESET; // [RL12]
		end else if (load_first) begin
			first_value_reg <= live_count_reg;
		end else if (wave && wr_i && addr_i == `TCC_OFF_FIRST) begin
			first_value_reg <= wdata_i[CNT_W-1:0]; // [RL9]
		end
	end

	// second value, same access rule
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			second_value_reg <= `TCC_CNT_RESET; // [RL12]
		end else if (load_second) begin
			second_value_reg <= live_count_reg;
		end else if (wave && wr_i && addr_i == `TCC_OFF_SECOND) begin
			second_value_reg <= wdata_i[CNT_W-1:0]; // [RL10]
		end
	end

	// period value, writable in both modes
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			period_value_reg <= `TCC_CNT_RESET; // [RL12]
		end else if (wr_i && addr_i == `TCC_OFF_PERIOD) begin
			period_value_reg <= wdata_i[CNT_W-1:0]; // [RL11]
		end
	end

	// loaded-but-unread markers; a new load beats the read
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			first_pend_reg  <= 1'b0;
			second_pend_reg <= 1'b0;
		end else begin
			if (load_first) begin
				first_pend_reg <= 1'b1;
			end else if (rd_i && addr_i == `TCC_OFF_FIRST) begin
				first_pend_reg <= 1'b0;
			end
			if (load_second) begin
				second_pend_reg <= 1'b1;
			end else if (rd_i && addr_i == `TCC_OFF_SECOND) begin
				second_pend_reg <= 1'b0;
			end
		end
	end

	// event sources and mode gating of each sticky flag
	always_comb begin
		flag_set = '0;
		flag_en  = '1;
		flag_set[`TCC_ST_WRAP]     = wrap_hit; // [RL13]
		flag_set[`TCC_ST_OVERRUN]  = overrun_hit; // [RL14]
		flag_set[`TCC_ST_FIRST_M]  = first_hit; // [RL15]
		flag_set[`TCC_ST_SECOND_M] = second_hit; // [RL16]
		flag_set[`TCC_ST_PERIOD_M] = period_hit; // [RL17]
		flag_set[`TCC_ST_FIRST_C]  = load_first; // [RL18]
		flag_set[`TCC_ST_SECOND_C] = load_second; // [RL19]
		flag_set[`TCC_ST_EXT_TRG]  = ext_trigger_i; // [RL20]
		flag_en[`TCC_ST_OVERRUN]   = !wave;
		flag_en[`TCC_ST_FIRST_C]   = !wave;
		flag_en[`TCC_ST_SECOND_C]  = !wave;
		flag_en[`TCC_ST_FIRST_M]   = wave;
		flag_en[`TCC_ST_SECOND_M]  = wave;
	end

	// one sticky cell per status flag
	for (genvar i = 0; i < `TCC_FLAG_COUNT; i++) begin : g_flag
		tcc_flag u_flag (
			.clk_sys_i (clk_sys_i),
			.rst_i     (rst_i),
			.en_i      (flag_en[i]),
			.set_i     (flag_set[i]),
			.clr_i     (status_rd),
			.q_o       (flags[i])
		);
	end

	// line a requests
	assign lna.en      = wave;
	assign lna.sw_hit  = sw_trig;
	assign lna.sw_act  = tcc_act_t'(mode_reg[`TCC_MODE_SW_A +: 2]); // [RL3]
	assign lna.ext_hit = ext_event_i;
	assign lna.ext_act = tcc_act_t'(mode_reg[`TCC_MODE_EXT_A +: 2]); // [RL2]
	assign lna.per_hit = period_hit;
	assign lna.per_act = tcc_act_t'(mode_reg[`TCC_MODE_PER_A +: 2]); // [RL1]
	assign lna.cmp_hit = 1'b0;
	assign lna.cmp_act = TCC_ACT_NONE;

	// line b requests
	assign lnb.en      = wave;
	assign lnb.sw_hit  = sw_trig;
	assign lnb.sw_act  = tcc_act_t'(mode_reg[`TCC_MODE_SW_B +: 2]); // [RL7]
	assign lnb.ext_hit = ext_event_i;
	assign lnb.ext_act = tcc_act_t'(mode_reg[`TCC_MODE_EXT_B +: 2]); // [RL6]
	assign lnb.per_hit = period_hit;
	assign lnb.per_act = tcc_act_t'(mode_reg[`TCC_MODE_PER_B +: 2]); // [RL5]
	assign lnb.cmp_hit = second_hit;
	assign lnb.cmp_act = tcc_act_t'(mode_reg[`TCC_MODE_SEC_B +: 2]); // [RL4]

	tcc_line_drv u_drv_a (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.ln        (lna.drv)
	);

	tcc_line_drv u_drv_b (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.ln        (lnb.drv)
	);

	// pins driven only in waveform mode
	assign line_a_o    = lna.level;
	assign line_b_o    = lnb.level;
	assign line_a_oe_o = wave; // [RL24]
	assign line_b_oe_o = wave;

	// line views: pin in capture mode, driven level in waveform mode
	assign view_a = wave ? lna.level : line_a_i; // [RL22]
	assign view_b = wave ? lnb.level : line_b_i; // [RL23]

	// read mux; unmapped and write-only offsets read zero
	always_comb begin
		rdata_next = '0;
		case (addr_i)
			`TCC_OFF_MODE: begin
				rdata_next = mode_reg;
			end
			`TCC_OFF_LIVE: begin
				rdata_next[CNT_W-1:0] = live_count_reg; // [RL8]
			end
			`TCC_OFF_FIRST: begin
				rdata_next[CNT_W-1:0] = first_value_reg; // [RL9]
			end
			`TCC_OFF_SECOND: begin
				rdata_next[CNT_W-1:0] = second_value_reg; // [RL10]
			end
			`TCC_OFF_PERIOD: begin
				rdata_next[CNT_W-1:0] = period_value_reg; // [RL11]
			end
			`TCC_OFF_STATUS: begin
				rdata_next[`TCC_FLAG_COUNT-1:0] = flags;
				rdata_next[`TCC_ST_CLK_ACT]     = count_clk_en_i; // [RL21]
				rdata_next[`TCC_ST_LINE_A]      = view_a;
				rdata_next[`TCC_ST_LINE_B]      = view_b;
			end
			default: begin
				rdata_next = '0;
			end
		endcase
	end

	// read data stand for one cycle after the strobe only
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= '0;
		end else if (rd_i) begin
			rdata_o <= rdata_next;
		end else begin
			rdata_o <= '0;
		end
	end

	count_step_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [RL8]
		step |=> live_count_reg == $past(count_next))
		else $error("live count did not advance on a tick");

	live_read_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [RL8]
		(rd_i && addr_i == `TCC_OFF_LIVE) |=> rdata_o == {16'h0000, $past(live_count_reg)})
		else $error("live count read returned wrong data");

	wrap_flag_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [RL13]
		wrap_hit |=> flags[`TCC_ST_WRAP] && live_count_reg == `TCC_CNT_RESET)
		else $error("overflow did not set the wrap flag");

	status_clear_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [RL13]
		(status_rd && flag_set == '0) |=> flags == '0)
		else $error("status read did not clear the flags");

	capture_lock_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [RL9]
		(!wave && wr_i && addr_i == `TCC_OFF_FIRST && !load_first_i) |=> $stable(first_value_reg))
		else $error("first value written in capture mode");

	overrun_set_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [RL14]
		(!wave && load_first_i && first_pend_reg) |=> flags[`TCC_ST_OVERRUN])
		else $error("double load did not flag an overrun");

	match_gate_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [RL15]
		(!wave && $past(!wave)) |-> !flags[`TCC_ST_FIRST_M] && !flags[`TCC_ST_SECOND_M])
		else $error("match flag set in capture mode");

	line_view_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [RL22]
		status_rd |=> rdata_o[`TCC_ST_LINE_A] == ($past(wave) ? $past(line_a_o) : $past(line_a_i))
		&& rdata_o[`TCC_ST_CLK_ACT] == $past(count_clk_en_i))
		else $error("status line view or clock bit wrong");

endmodule

/* logic/tcc_chan_regs.svh */
/*
 * Register offsets, field positions, reset values and widths of the timer channel.
 * Assumes it is included by its bare name; holds definitions only.
 */
`ifndef TCC_CHAN_REGS_SVH
`define TCC_CHAN_REGS_SVH

// byte offsets on the register port
`define TCC_OFF_CTRL      8'h00
`define TCC_OFF_MODE      8'h04
`define TCC_OFF_LIVE      8'h10
`define TCC_OFF_FIRST     8'h14
`define TCC_OFF_SECOND    8'h18
`define TCC_OFF_PERIOD    8'h1c
`define TCC_OFF_STATUS    8'h20

// control register: write-only command bits
`define TCC_CTRL_SWTRIG   0

// mode register fields
`define TCC_MODE_WAVE     15
`define TCC_MODE_PER_A    18
`define TCC_MODE_EXT_A    20
`define TCC_MODE_SW_A     22
`define TCC_MODE_SEC_B    24
`define TCC_MODE_PER_B    26
`define TCC_MODE_EXT_B    28
`define TCC_MODE_SW_B     30

// status register bits
`define TCC_ST_WRAP       0
`define TCC_ST_OVERRUN    1
`define TCC_ST_FIRST_M    2
`define TCC_ST_SECOND_M   3
`define TCC_ST_PERIOD_M   4
`define TCC_ST_FIRST_C    5
`define TCC_ST_SECOND_C   6
`define TCC_ST_EXT_TRG    7
`define TCC_ST_CLK_ACT    16
`define TCC_ST_LINE_A     17
`define TCC_ST_LINE_B     18

// reset and limit values
`define TCC_CNT_RESET     16'h0000
`define TCC_CNT_MAX       16'hffff
`define TCC_MODE_RESET    32'h0000_0000
`define TCC_FLAG_COUNT    8

`endif

/* logic/tcc_pkg.sv */
/*
 * Types shared by the timer channel modules.
 * Assumes the register header supplies all numeric constants.
 */
package tcc_pkg;

	// two-bit output action code
	typedef enum logic [1:0] {
		TCC_ACT_NONE   = 2'h0,
		TCC_ACT_SET    = 2'h1,
		TCC_ACT_CLEAR  = 2'h2,
		TCC_ACT_TOGGLE = 2'h3
	} tcc_act_t;

	typedef logic [7:0]  tcc_addr_t;
	typedef logic [31:0] tcc_data_t;
	typedef logic [15:0] tcc_word_t;

endpackage

/* logic/tcc_line_if.sv */
/*
 * Interface between the channel core and one line driver: hit strobes with action codes in,
 * driven level out. Assumes one instance per channel line, all on clk_sys_i.
 */
`timescale 1ns/1ps
interface tcc_line_if;
	import tcc_pkg::*;

	logic     en;
	logic     sw_hit;
	tcc_act_t sw_act;
	logic     ext_hit;
	tcc_act_t ext_act;
	logic     per_hit;
	tcc_act_t per_act;
	logic     cmp_hit;
	tcc_act_t cmp_act;
	logic     level;

	modport drv (input en, sw_hit, sw_act, ext_hit, ext_act, per_hit, per_act, cmp_hit, cmp_act,
		output level);
	modport ctl (output en, sw_hit, sw_act, ext_hit, ext_act, per_hit, per_act, cmp_hit, cmp_act,
		input level);
endinterface

/* logic/tcc_flag.sv */
/*
 * One sticky event flag: set by hardware, cleared by a status read, forced low when disabled.
 * Assumes set and clear are one-cycle pulses on clk_sys_i.
 */
`timescale 1ns/1ps
module tcc_flag (
	// clock and reset
	input  wire logic clk_sys_i,
	input  wire logic rst_i,
	// control
	input  wire logic en_i,
	input  wire logic set_i,
	input  wire logic clr_i,
	// state
	output logic      q_o
);

	// set beats clear so an event in the read cycle survives
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			q_o <= 1'b0;
		end else if (!en_i) begin
			q_o <= 1'b0;
		end else if (set_i) begin
			q_o <= 1'b1; // [RL25]
		end else if (clr_i) begin
			q_o <= 1'b0;
		end
	end

	set_wins_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [RL25]
		(en_i && set_i && clr_i) |=> q_o)
		else $error("flag lost an event set during its clear");

endmodule

/* logic/tcc_line_drv.sv */
/*
 * Drives one channel line from prioritised action requests.
 * Assumes hit strobes are one-cycle pulses; software beats external event beats compares.
 */
`timescale 1ns/1ps
module tcc_line_drv (
	// clock and reset
	input  wire logic clk_sys_i,
	input  wire logic rst_i,
	// requests and level
	tcc_line_if.drv   ln
);
	import tcc_pkg::*;

	// apply one action code to a level
	function automatic logic act_apply(input logic cur, input tcc_act_t act);
		case (act)
			TCC_ACT_SET:    act_apply = 1'b1;
			TCC_ACT_CLEAR:  act_apply = 1'b0;
			TCC_ACT_TOGGLE: act_apply = ~cur;
			default:        act_apply = cur;
		endcase
	endfunction

	logic level_next;

	// fixed priority, an idle code lets the next source through
	always_comb begin
		level_next = ln.level;
		if (ln.sw_hit && ln.sw_act != TCC_ACT_NONE) begin
			level_next = act_apply(ln.level, ln.sw_act); // [RL3] [RL7] [RL26]
		end else if (ln.ext_hit && ln.ext_act != TCC_ACT_NONE) begin
			level_next = act_apply(ln.level, ln.ext_act); // [RL2] [RL6]
		end else if (ln.per_hit && ln.per_act != TCC_ACT_NONE) begin
			level_next = act_apply(ln.level, ln.per_act); // [RL1] [RL5]
		end else if (ln.cmp_hit) begin
			level_next = act_apply(ln.level, ln.cmp_act); // [RL4]
		end
	end

	// driven level, held while waveform mode is off
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			ln.level <= 1'b0;
		end else if (ln.en) begin
			ln.level <= level_next;
		end
	end

	sw_first_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [RL26]
		(ln.en && ln.sw_hit && ln.sw_act == TCC_ACT_SET) |=> ln.level)
		else $error("software set did not win on the line");

	toggle_act_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [RL1]
		(ln.en && !ln.sw_hit && !ln.ext_hit && ln.per_hit && ln.per_act == TCC_ACT_TOGGLE)
		|=> ln.level != $past(ln.level))
		else $error("period toggle did not invert the line");

endmodule

/* verification/tcc_pin_model.sv */
/*
 * Outside world on the two channel lines: a line the channel drives reads back its driven level,
 * a released line shows whatever level the bench puts on it from outside.
 * Assumes the bench changes the outside levels only just after a rising clock edge.
 */
`timescale 1ns/1ps
module tcc_pin_model (
	// driven side of the channel
	input  wire logic a_drv_i,
	input  wire logic a_oe_i,
	input  wire logic b_drv_i,
	input  wire logic b_oe_i,
	// levels put on released lines from outside
	input  wire logic a_ext_i,
	input  wire logic b_ext_i,
	// resolved pin levels
	output logic      a_pin_o,
	output logic      b_pin_o
);
	// the driver wins while enabled, otherwise the outside source sets the pin
	assign a_pin_o = a_oe_i ? a_drv_i : a_ext_i;
	assign b_pin_o = b_oe_i ? b_drv_i : b_ext_i;
endmodule

/* verification/tcc_chan_test.sv */
/*
 * Self-checking bench of one timer channel: registers, line actions, sticky status flags.
 * Assumes the register header and the package of the design are compiled first.
 */
`timescale 1ns/1ps
`include "tcc_chan_regs.svh"
module tcc_chan_test;
	import tcc_pkg::*;
	localparam int LIMIT = 80000;
	// design stimulus and responses
	logic        clk_sys_i, rst_i, wr_i, rd_i;
	tcc_addr_t   addr_i;
	tcc_data_t   wdata_i, rdata_o;
	logic        count_tick_i, count_clk_en_i, ext_event_i, ext_trigger_i, load_first_i, load_second_i;
	logic        line_a_i, line_a_o, line_a_oe_o, line_b_i, line_b_o, line_b_oe_o;
	logic        pin_a_ext, pin_b_ext;
	// bench bookkeeping and expected state
	int          error_cnt, check_count, cyc;
	logic [15:0] cnt;
	logic        la, lb;
	tcc_data_t   d, r;
	tcc_addr_t   offs [4] = '{`TCC_OFF_LIVE, `TCC_OFF_FIRST, `TCC_OFF_SECOND, `TCC_OFF_PERIOD};

	tcc_chan #(.CNT_W(16)) u_tcc_chan (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .count_tick_i(count_tick_i),
		.count_clk_en_i(count_clk_en_i), .ext_event_i(ext_event_i), .ext_trigger_i(ext_trigger_i),
		.load_first_i(load_first_i), .load_second_i(load_second_i), .line_a_i(line_a_i),
		.line_a_o(line_a_o), .line_a_oe_o(line_a_oe_o), .line_b_i(line_b_i), .line_b_o(line_b_o),
		.line_b_oe_o(line_b_oe_o));
	tcc_pin_model u_tcc_pin_model (.a_drv_i(line_a_o), .a_oe_i(line_a_oe_o), .b_drv_i(line_b_o),
		.b_oe_i(line_b_oe_o), .a_ext_i(pin_a_ext), .b_ext_i(pin_b_ext), .a_pin_o(line_a_i),
		.b_pin_o(line_b_i));

	// 40 mhz clock
	initial begin
		clk_sys_i = 1'b0;
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end
	// hang guard
	always @(posedge clk_sys_i) begin
		cyc = cyc + 1;
		if (cyc == LIMIT) begin
			error_cnt++;
			$display("unexpected at %0t: run did not finish", $time);
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk_word(input tcc_data_t got, input tcc_data_t exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: level %b, wanted %b", $time, got, exp);
		end
	endtask
	// one write cycle on the register port
	task automatic wr(input tcc_addr_t a, input tcc_data_t v);
		@(posedge clk_sys_i);
		wr_i    <= 1'b1;
		addr_i  <= a;
		wdata_i <= v;
		@(posedge clk_sys_i);
		wr_i    <= 1'b0;
	endtask
	// one read cycle, optionally with an external trigger in the same cycle
	task automatic rd(input tcc_addr_t a, input logic trg, output tcc_data_t v);
		@(posedge clk_sys_i);
		rd_i          <= 1'b1;
		addr_i        <= a;
		ext_trigger_i <= trg;
		@(posedge clk_sys_i);
		rd_i          <= 1'b0;
		ext_trigger_i <= 1'b0;
		#1 v = rdata_o;
	endtask
	task automatic rchk(input tcc_addr_t a, input tcc_data_t exp);
		rd(a, 1'b0, d);
		chk_word(d, exp);
	endtask
	// one-cycle pulses: tick, external event, trigger, first load, second load
	task automatic ev(input logic [4:0] m);
		@(posedge clk_sys_i);
		{count_tick_i, ext_event_i, ext_trigger_i, load_first_i, load_second_i} <= m;
		@(posedge clk_sys_i);
		{count_tick_i, ext_event_i, ext_trigger_i, load_first_i, load_second_i} <= 5'h00;
		if (m[4] && count_clk_en_i) cnt++;
	endtask
	// n ticks back to back
	task automatic run(input int n);
		@(posedge clk_sys_i);
		count_tick_i <= 1'b1;
		repeat (n) @(posedge clk_sys_i);
		count_tick_i <= 1'b0;
		cnt = cnt + 16'(n);
	endtask
	// line levels, drive enables and the status mirrors
	task automatic lines();
		repeat (3) @(posedge clk_sys_i);
		#1;
		chk_bit(line_a_o, la);
		chk_bit(line_b_o, lb);
		chk_bit(line_a_oe_o & line_b_oe_o, 1'b1);
		rd(`TCC_OFF_STATUS, 1'b0, d);
		chk_word(d & 32'h0007_0000, {13'h0000, lb, la, count_clk_en_i, 16'h0000});
	endtask
	function automatic logic act_f(input logic cur, input logic [1:0] c);
		case (c)
			2'h1: return 1'b1;
			2'h2: return 1'b0;
			2'h3: return ~cur;
			default: return cur;
		endcase
	endfunction
	// waveform mode with code c on the fields of one action source
	function automatic tcc_data_t mode_f(input logic [1:0] c, input int s);
		tcc_data_t m;
		m = 32'h0000_0000;
		m[`TCC_MODE_WAVE] = 1'b1;
		case (s)
			0: m = m | ({30'h0, c} << `TCC_MODE_SW_A) | ({30'h0, c} << `TCC_MODE_SW_B);
			1: m = m | ({30'h0, c} << `TCC_MODE_EXT_A) | ({30'h0, c} << `TCC_MODE_EXT_B);
			2: m = m | ({30'h0, c} << `TCC_MODE_PER_A) | ({30'h0, c} << `TCC_MODE_PER_B);
			default: m = m | ({30'h0, c} << `TCC_MODE_SEC_B);
		endcase
		return m;
	endfunction
	function automatic tcc_data_t bitm(input int b);
		return 32'h0000_0001 << b;
	endfunction

	initial begin
		{rst_i, wr_i, rd_i, count_tick_i, ext_event_i, ext_trigger_i, load_first_i, load_second_i} = 8'h80;
		addr_i = 8'h00;
		wdata_i = 32'h0000_0000;
		{count_clk_en_i, pin_a_ext, pin_b_ext} = 3'h5;
		error_cnt = 0;
		check_count = 0;
		cyc = 0;
		{cnt, la, lb} = 18'h00000;
		void'($urandom(32'h8554f29f));
		repeat (10) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		// reset values, then access rules in capture mode
		for (int i = 0; i < 4; i++) begin
			rchk(offs[i], 32'h0000_0000);
		end
		r = $urandom | 32'h0000_8000;
		for (int i = 0; i < 4; i++) begin
			wr(offs[i], r);
		end
		rchk(`TCC_OFF_LIVE, 32'h0000_0000);
		rchk(`TCC_OFF_FIRST, 32'h0000_0000);
		rchk(`TCC_OFF_SECOND, 32'h0000_0000);
		rchk(`TCC_OFF_PERIOD, r & 32'h0000_ffff);
		rchk(8'h3c, 32'h0000_0000);
		// waveform mode opens the first and second values to writes
		wr(`TCC_OFF_MODE, mode_f(2'h0, 0));
		rchk(`TCC_OFF_MODE, mode_f(2'h0, 0));
		for (int i = 1; i < 3; i++) begin
			r = $urandom | 32'h0000_8000;
			wr(offs[i], r);
			rchk(offs[i], r & 32'h0000_ffff);
		end
		$display("test registers done");
		// every action code of every source on both lines, except the second compare, which drives line B only
		for (int s = 0; s < 4; s++) begin
			for (int c = 0; c < 4; c++) begin
				wr(`TCC_OFF_MODE, mode_f(2'(c), s));
				case (s)
					0: wr(`TCC_OFF_CTRL, 32'h0000_0001);
					1: ev(5'h08);
					2: wr(`TCC_OFF_PERIOD, {16'h0000, cnt + 16'h0001});
					default: wr(`TCC_OFF_SECOND, {16'h0000, cnt + 16'h0001});
				endcase
				if (s > 1) ev(5'h10);
				if (s != 3) la = act_f(la, 2'(c));
				lb = act_f(lb, 2'(c));
				lines();
			end
		end
		// external event beats period match; a none code does not block it
		for (int k = 0; k < 2; k++) begin
			d = mode_f(2'h1, 2) | ({30'h0, (k == 0) ? 2'h2 : 2'h0} << `TCC_MODE_EXT_A);
			d = d | ({30'h0, (k == 0) ? 2'h2 : 2'h0} << `TCC_MODE_EXT_B);
			wr(`TCC_OFF_MODE, d);
			wr(`TCC_OFF_PERIOD, {16'h0000, cnt + 16'h0001});
			ev(5'h18);
			la = (k == 1);
			lb = (k == 1);
			lines();
		end
		$display("test line actions done");
		// match and trigger flags in waveform mode; a first load ignored there
		rd(`TCC_OFF_STATUS, 1'b0, d);
		for (int i = 1; i < 4; i++) begin
			wr(offs[i], {16'h0000, cnt + 16'(i)});
		end
		repeat (3) ev(5'h10);
		ev(5'h04);
		ev(5'h02);
		rd(`TCC_OFF_STATUS, 1'b0, d);
		r = bitm(`TCC_ST_FIRST_M) | bitm(`TCC_ST_SECOND_M) | bitm(`TCC_ST_PERIOD_M) | bitm(`TCC_ST_EXT_TRG);
		chk_word(d & 32'h0000_00ff, r);
		rchk(`TCC_OFF_LIVE, {16'h0000, cnt});
		rchk(`TCC_OFF_STATUS, {13'h0000, lb, la, 17'h10000});
		$display("test waveform flags done");
		// full wrap in capture mode passes all three values
		for (int i = 1; i < 4; i++) begin
			wr(offs[i], 32'h0000_fff0 + i);
		end
		wr(`TCC_OFF_MODE, 32'h0000_0000);
		rd(`TCC_OFF_STATUS, 1'b0, d);
		run(int'(32'h0001_0000 - {16'h0000, cnt}));
		rd(`TCC_OFF_STATUS, 1'b0, d);
		chk_word(d & 32'h0000_00ff, bitm(`TCC_ST_WRAP) | bitm(`TCC_ST_PERIOD_M));
		rchk(`TCC_OFF_LIVE, 32'h0000_0000);
		// captures, overrun, and an event during the clearing read
		ev(5'h10);
		ev(5'h02);
		ev(5'h10);
		ev(5'h01);
		r = {13'h0000, pin_b_ext, pin_a_ext, 17'h10000};
		rchk(`TCC_OFF_STATUS, bitm(`TCC_ST_FIRST_C) | bitm(`TCC_ST_SECOND_C) | r);
		rchk(`TCC_OFF_FIRST, {16'h0000, cnt - 16'h0001});
		rchk(`TCC_OFF_SECOND, {16'h0000, cnt});
		ev(5'h02);
		ev(5'h02);
		rd(`TCC_OFF_STATUS, 1'b0, d);
		chk_word(d & 32'h0000_00ff, bitm(`TCC_ST_OVERRUN) | bitm(`TCC_ST_FIRST_C));
		rd(`TCC_OFF_STATUS, 1'b1, d);
		rd(`TCC_OFF_STATUS, 1'b0, d);
		chk_word(d & 32'h0000_00ff, bitm(`TCC_ST_EXT_TRG));
		$display("test capture flags done");
		// released lines mirror the pins; clock-active bit follows its input
		repeat (4) begin
			@(posedge clk_sys_i);
			pin_a_ext      <= 1'($urandom);
			pin_b_ext      <= 1'($urandom);
			count_clk_en_i <= 1'($urandom);
			rd(`TCC_OFF_STATUS, 1'b0, d);
			chk_word(d & 32'h0007_0000, {13'h0000, pin_b_ext, pin_a_ext, count_clk_en_i, 16'h0000});
			chk_bit(line_a_oe_o | line_b_oe_o, 1'b0);
		end
		$display("test capture mirrors done");
		tally_and_finish();
	end
endmodule
